// ==== src/hbl_pkg.sv ====
package hbl_pkg;
  localparam int HBL_NBIN = 6;
  localparam int HBL_LOG_DEPTH = 4096;
  localparam int HBL_DW = 16;
  // Register byte offsets
  localparam logic [7:0] HBL_OFF_CTRL = 8'h00;
  localparam logic [7:0] HBL_OFF_STATUS = 8'h04;
  localparam logic [7:0] HBL_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] HBL_OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] HBL_OFF_CNT_EN = 8'h10;
  localparam logic [7:0] HBL_OFF_VAL_KEEP = 8'h14;
  localparam logic [7:0] HBL_OFF_STAMP_KEEP = 8'h18;
  localparam logic [7:0] HBL_OFF_ALARM = 8'h1C;
  localparam logic [7:0] HBL_OFF_LOG_PTR = 8'h20;
  localparam logic [7:0] HBL_OFF_LOG_DATA = 8'h24;
  localparam logic [7:0] HBL_OFF_UPPER = 8'h40;
  localparam logic [7:0] HBL_OFF_PERIOD = 8'h80;
  localparam logic [7:0] HBL_OFF_LEVEL = 8'hC0;
  // Bank: 12 words per table, temperature 0..5, humidity 6..11
  localparam int HBL_TBL_WORDS = 12;
  // Control bits
  localparam int HBL_CTRL_START = 0;
  localparam int HBL_CTRL_STOP = 1;
  localparam int HBL_CTRL_RESET = 2;
  // Interrupt bits
  localparam int HBL_IRQ_ALARM = 0;
  localparam int HBL_IRQ_SLEEP = 1;
  localparam int HBL_IRQ_FULL = 2;
  // Reset values
  localparam logic [11:0] HBL_CNT_EN_RST = 12'h041;
  localparam logic [11:0] HBL_VAL_KEEP_RST = 12'h041;
  localparam logic [11:0] HBL_STAMP_KEEP_RST = 12'h000;
  localparam logic [15:0] HBL_UPPER_T0_RST = 16'h08C0;
  localparam logic [15:0] HBL_UPPER_H0_RST = 16'h0C80;
  localparam logic [15:0] HBL_PERIOD_RST = 16'h001E;
  localparam logic [15:0] HBL_LEVEL_OFF = 16'hFFFF;
  localparam logic [15:0] HBL_RANGE_MIN = 16'h0000;
  localparam logic [1:0] HBL_BAT_EMPTY = 2'h0;
  // Sampling period in seconds
  localparam int HBL_PERIOD_MIN_S = 5;
  localparam int HBL_PERIOD_MAX_H = 18;
  localparam logic [15:0] HBL_PERIOD_MIN = 16'(HBL_PERIOD_MIN_S);
  localparam logic [15:0] HBL_PERIOD_MAX = 16'(HBL_PERIOD_MAX_H * 3600);
  localparam int HBL_CLK_HZ = 10000000;
  localparam int HBL_TICKS_PER_S = HBL_CLK_HZ;
  typedef enum logic [1:0] {HBL_IDLE, HBL_ACTIVE, HBL_SLEEP} hbl_state_t;
  typedef struct packed {
    logic is_hum;
    logic [15:0] value;
  } hbl_sample_t;
  typedef struct packed {
    logic is_hum;
    logic has_value;
    logic has_stamp;
    logic [2:0] bin;
    logic [15:0] value;
    logic [31:0] stamp;
  } hbl_log_t;
endpackage

// ==== src/hbl_logger.sv ====
`timescale 1ns/10ps
module hbl_logger
  import hbl_pkg::*;
#(
  parameter int TICKS_PER_S = HBL_TICKS_PER_S
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Sensor samples
  input wire logic smp_valid_i,
  input wire hbl_sample_t smp_i,
  input wire logic [1:0] bat_level_i,
  // Status outputs
  output logic sample_req_o,
  output hbl_state_t state_o,
  output logic irq_o
);
  hbl_state_t state_reg;
  logic [11:0] cnt_en_reg, val_keep_reg, stamp_keep_reg, alarm_reg;
  logic [15:0] upper_reg [HBL_TBL_WORDS];
  logic [15:0] period_reg [HBL_TBL_WORDS];
  logic [15:0] level_reg [HBL_TBL_WORDS];
  logic [15:0] hits_reg [HBL_TBL_WORDS];
  logic [2:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic [12:0] log_ptr_reg;
  hbl_log_t log_mem [HBL_LOG_DEPTH];
  logic [31:0] time_reg, tick_reg;
  logic sec_pulse;
  logic [15:0] interval_reg, wait_reg;
  logic [3:0] last_bin_reg;
  logic ack_reg;
  logic [31:0] rdata_next;
  logic [11:0] wr_mask;
  logic start_cmd, stop_cmd, reset_cmd;
  logic [11:0] hit_vec;
  logic [3:0] hit_idx;
  logic hit_any;
  logic [15:0] lower_b [HBL_TBL_WORDS];
  logic acc;
  logic [15:0] per_sel;
  hbl_log_t last_ent;

  wire wr_go = avs_write_i && !ack_reg;
  wire rd_go = avs_read_i && !ack_reg;
  assign start_cmd = wr_go && avs_address_i == HBL_OFF_CTRL && avs_writedata_i[HBL_CTRL_START];
  assign stop_cmd = wr_go && avs_address_i == HBL_OFF_CTRL && avs_writedata_i[HBL_CTRL_STOP];
  assign reset_cmd = wr_go && avs_address_i == HBL_OFF_CTRL && avs_writedata_i[HBL_CTRL_RESET];
  assign acc = smp_valid_i && state_reg == HBL_ACTIVE;
  wire log_full = log_ptr_reg == 13'(HBL_LOG_DEPTH);

  // Bin classification, one comparator pair per bin
  genvar g;
  generate
    for (g = 0; g < HBL_TBL_WORDS; g++) begin : g_bin
      if (g % HBL_NBIN == 0) begin : g_first
        assign lower_b[g] = HBL_RANGE_MIN;
      end else begin : g_rest
        assign lower_b[g] = upper_reg[g-1];
      end
      // Bin zero includes the range minimum itself
      assign hit_vec[g] = (smp_i.is_hum == (g >= HBL_NBIN)) &&
        ((g % HBL_NBIN == 0) ? smp_i.value >= lower_b[g] : smp_i.value > lower_b[g]) &&
        smp_i.value <= upper_reg[g];
    end
  endgenerate

  always_comb begin
    hit_idx = 4'h0;
    hit_any = 1'b0;
    for (int i = HBL_TBL_WORDS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 4'(i);
        hit_any = 1'b1;
      end
    end
  end

  // One-second enable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || tick_reg == 32'(TICKS_PER_S - 1)) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end
  assign sec_pulse = tick_reg == 32'(TICKS_PER_S - 1);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      time_reg <= 32'h0;
    end else if (sec_pulse) begin
      time_reg <= time_reg + 32'h1;
    end
  end

  // Operating state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= HBL_IDLE;
    end else begin
      unique case (state_reg)
        HBL_IDLE: if (start_cmd) state_reg <= HBL_ACTIVE;
        HBL_ACTIVE: begin
          if (stop_cmd || log_full || bat_level_i == HBL_BAT_EMPTY) begin
            state_reg <= HBL_SLEEP;
          end
        end
        HBL_SLEEP: if (reset_cmd) state_reg <= HBL_IDLE;
      endcase
    end
  end

  // Sampling interval, clamped to the supported span
  always_comb begin
    per_sel = period_reg[hit_idx];
    if (per_sel < HBL_PERIOD_MIN) per_sel = HBL_PERIOD_MIN;
    if (per_sel > HBL_PERIOD_MAX) per_sel = HBL_PERIOD_MAX;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state_reg == HBL_IDLE) begin
      interval_reg <= HBL_PERIOD_RST;
      last_bin_reg <= 4'hF;
      wait_reg <= 16'h0;
      sample_req_o <= 1'b0;
    end else begin
      sample_req_o <= 1'b0;
      if (acc && hit_any && hit_idx != last_bin_reg) begin
        interval_reg <= per_sel;
        wait_reg <= per_sel;
      end else if (acc) begin
        wait_reg <= interval_reg;
      end else if (state_reg == HBL_ACTIVE && sec_pulse) begin
        if (wait_reg <= 16'h1) begin
          sample_req_o <= 1'b1;
          wait_reg <= interval_reg;
        end else begin
          wait_reg <= wait_reg - 16'h1;
        end
      end
      if (acc && hit_any) last_bin_reg <= hit_idx;
    end
  end

  // Hit counters and alarms
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < HBL_TBL_WORDS; i++) begin
      if (rst_i || (state_reg == HBL_SLEEP && reset_cmd)) begin
        hits_reg[i] <= 16'h0;
        alarm_reg[i] <= 1'b0;
      end else begin
        if (acc && hit_vec[i] && cnt_en_reg[i] && hits_reg[i] != 16'hFFFF) begin
          hits_reg[i] <= hits_reg[i] + 16'h1;
        end
        alarm_reg[i] <= level_reg[i] != HBL_LEVEL_OFF &&
          hits_reg[i] >= level_reg[i];
      end
    end
  end

  // Log memory write
  wire keep_v = val_keep_reg[hit_idx];
  wire keep_s = stamp_keep_reg[hit_idx];
  wire log_go = acc && hit_any && cnt_en_reg[hit_idx] && (keep_v || keep_s) && !log_full;
  always_ff @(posedge sys_clk_i) begin
    if (log_go) begin
      log_mem[log_ptr_reg[11:0]] <= '{is_hum: smp_i.is_hum, has_value: keep_v,
        has_stamp: keep_s, bin: 3'(hit_idx % 4'(HBL_NBIN)),
        value: keep_v ? smp_i.value : 16'h0, stamp: keep_s ? time_reg : 32'h0};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (state_reg == HBL_SLEEP && reset_cmd)) begin
      log_ptr_reg <= 13'h0;
    end else if (log_go) begin
      log_ptr_reg <= log_ptr_reg + 13'h1;
    end
  end
  // Newest entry, read back through the log data word; an empty log reads zero
  assign last_ent = (log_ptr_reg == 13'h0) ? '0 : log_mem[12'(log_ptr_reg - 13'h1)];

  // Interrupt status
  assign irq_set = {log_go && log_ptr_reg == 13'(HBL_LOG_DEPTH - 1),
    state_reg == HBL_ACTIVE && (stop_cmd || log_full || bat_level_i == HBL_BAT_EMPTY),
    |alarm_reg};
  assign wr_mask = avs_writedata_i[11:0];
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
    end else if (wr_go && avs_address_i == HBL_OFF_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~avs_writedata_i[2:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    irq_o <= !rst_i && |(irq_stat_reg & irq_mask_reg);
  end

  // Configuration writes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_en_reg <= HBL_CNT_EN_RST;
      val_keep_reg <= HBL_VAL_KEEP_RST;
      stamp_keep_reg <= HBL_STAMP_KEEP_RST;
      irq_mask_reg <= 3'h0;
      for (int i = 0; i < HBL_TBL_WORDS; i++) begin
        upper_reg[i] <= (i == 0) ? HBL_UPPER_T0_RST :
          (i == HBL_NBIN) ? HBL_UPPER_H0_RST : 16'h0000;
        period_reg[i] <= HBL_PERIOD_RST;
        level_reg[i] <= HBL_LEVEL_OFF;
      end
    end else if (wr_go) begin
      if (avs_address_i == HBL_OFF_CNT_EN) cnt_en_reg <= wr_mask;
      if (avs_address_i == HBL_OFF_VAL_KEEP) val_keep_reg <= wr_mask;
      if (avs_address_i == HBL_OFF_STAMP_KEEP) stamp_keep_reg <= wr_mask;
      if (avs_address_i == HBL_OFF_IRQ_MASK) irq_mask_reg <= avs_writedata_i[2:0];
      for (int i = 0; i < HBL_TBL_WORDS; i++) begin
        if (avs_address_i == HBL_OFF_UPPER + 8'(4 * i)) upper_reg[i] <= avs_writedata_i[15:0];
        if (avs_address_i == HBL_OFF_PERIOD + 8'(4 * i)) period_reg[i] <= avs_writedata_i[15:0];
        if (avs_address_i == HBL_OFF_LEVEL + 8'(4 * i)) level_reg[i] <= avs_writedata_i[15:0];
      end
    end
  end

  // Read decode; hit counters sit in the high half of the level words
  always_comb begin
    rdata_next = 32'h0;
    unique case (avs_address_i)
      HBL_OFF_STATUS: rdata_next = {28'h0, bat_level_i, state_reg};
      HBL_OFF_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
      HBL_OFF_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
      HBL_OFF_CNT_EN: rdata_next = {20'h0, cnt_en_reg};
      HBL_OFF_VAL_KEEP: rdata_next = {20'h0, val_keep_reg};
      HBL_OFF_STAMP_KEEP: rdata_next = {20'h0, stamp_keep_reg};
      HBL_OFF_ALARM: rdata_next = {20'h0, alarm_reg};
      HBL_OFF_LOG_PTR: rdata_next = {19'h0, log_ptr_reg};
      HBL_OFF_LOG_DATA: rdata_next = {last_ent.is_hum, last_ent.has_value, last_ent.has_stamp,
        last_ent.bin, 10'h0, last_ent.value};
      default: begin
        for (int i = 0; i < HBL_TBL_WORDS; i++) begin
          if (avs_address_i == HBL_OFF_UPPER + 8'(4 * i)) rdata_next = {16'h0, upper_reg[i]};
          if (avs_address_i == HBL_OFF_PERIOD + 8'(4 * i)) rdata_next = {16'h0, period_reg[i]};
          if (avs_address_i == HBL_OFF_LEVEL + 8'(4 * i)) rdata_next = {hits_reg[i], level_reg[i]};
        end
      end
    endcase
  end

  // One wait state per access
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      ack_reg <= (rd_go || wr_go);
      avs_waitrequest_o <= !(rd_go || wr_go);
      if (rd_go) avs_readdata_o <= rdata_next;
    end
  end
  assign state_o = state_reg;

  // Checks
  AST_IDLE_START: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_IDLE && start_cmd |=> state_reg == HBL_ACTIVE)
    else $error("start did not activate");
  AST_SLEEP_RESET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_SLEEP && reset_cmd |=> state_reg == HBL_IDLE && log_ptr_reg == 13'h0)
    else $error("reset did not return idle");
  AST_SLEEP_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_SLEEP && !reset_cmd |=> $stable(log_ptr_reg) && state_reg == HBL_SLEEP)
    else $error("sleep log changed");
  AST_BAT_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_ACTIVE && bat_level_i == HBL_BAT_EMPTY |=> state_reg == HBL_SLEEP)
    else $error("empty battery ignored");
  AST_CNT_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !cnt_en_reg[2] && !(state_reg == HBL_SLEEP && reset_cmd) |=> $stable(hits_reg[2]))
    else $error("disabled bin counted");
  AST_CNT_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_vec[0] && cnt_en_reg[0] && hits_reg[0] < 16'h00FF |=> hits_reg[0] == $past(hits_reg[0]) + 16'h1)
    else $error("enabled bin missed");
  AST_ALARM_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    level_reg[0] == HBL_LEVEL_OFF ##1 level_reg[0] == HBL_LEVEL_OFF |-> !alarm_reg[0])
    else $error("suppressed alarm raised");
  AST_ALARM_ON: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    level_reg[1] != HBL_LEVEL_OFF && hits_reg[1] >= level_reg[1] &&
    !(state_reg == HBL_SLEEP && reset_cmd) |=> alarm_reg[1])
    else $error("alarm missing");
  AST_LOG_CAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    log_ptr_reg <= 13'(HBL_LOG_DEPTH))
    else $error("log overflow");
  AST_PERIOD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    interval_reg >= HBL_PERIOD_MIN && interval_reg <= HBL_PERIOD_MAX)
    else $error("interval out of span");
  // Classification, logging and state checks
  AST_IDLE_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_IDLE |=> !sample_req_o)
    else $error("sample request while idle");
  AST_IDLE_EMPTY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_IDLE |=> log_ptr_reg == 13'h0)
    else $error("log not empty while idle");
  AST_REQ_ACTIVE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sample_req_o |-> state_reg != HBL_IDLE)
    else $error("sample request outside logging");
  AST_STOP_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_ACTIVE && stop_cmd |=> state_reg == HBL_SLEEP)
    else $error("stop did not sleep");
  AST_SLEEP_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_ACTIVE && stop_cmd |=> irq_stat_reg[HBL_IRQ_SLEEP])
    else $error("sleep flag missing");
  AST_HUM_SPLIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    smp_i.is_hum |-> hit_vec[5:0] == 6'h00)
    else $error("humidity sample hit temperature bin");
  AST_BIN_LOWER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !smp_i.is_hum && smp_i.value == upper_reg[0] |-> !hit_vec[1])
    else $error("bin lower bound included");
  AST_BIN0_MIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !smp_i.is_hum && smp_i.value == HBL_RANGE_MIN |-> hit_vec[0])
    else $error("range minimum missed");
  AST_CNT_HUM: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_vec[6] && cnt_en_reg[6] && hits_reg[6] < 16'h00FF |=>
    hits_reg[6] == $past(hits_reg[6]) + 16'h1)
    else $error("humidity bin missed");
  AST_NEW_BIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_any && hit_idx != last_bin_reg |=> interval_reg == $past(per_sel))
    else $error("new bin period not loaded");
  AST_SAME_BIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_any && hit_idx == last_bin_reg |=> $stable(interval_reg))
    else $error("interval changed in same bin");
  AST_NO_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_any && !val_keep_reg[hit_idx] && !stamp_keep_reg[hit_idx] |=>
    $stable(log_ptr_reg))
    else $error("sample logged without keep bit");
  AST_STAMP_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    acc && hit_any && cnt_en_reg[hit_idx] && stamp_keep_reg[hit_idx] && !log_full |=>
    log_ptr_reg == $past(log_ptr_reg) + 13'h1)
    else $error("stamp entry not logged");
  AST_FULL_SLEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_ACTIVE && log_full |=> state_reg == HBL_SLEEP)
    else $error("full log did not sleep");
  AST_RESET_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    state_reg == HBL_SLEEP && reset_cmd |=> hits_reg[1] == 16'h0 && alarm_reg == 12'h0)
    else $error("reset left counters or alarms");
  COV_START: cover property (@(posedge sys_clk_i) state_reg == HBL_IDLE ##1 state_reg == HBL_ACTIVE);
  COV_LOG: cover property (@(posedge sys_clk_i) log_go ##1 log_go);
  COV_ALARM: cover property (@(posedge sys_clk_i) $rose(irq_o));
  COV_CYCLE: cover property (@(posedge sys_clk_i) state_reg == HBL_SLEEP ##1 state_reg == HBL_IDLE);
  COV_FULL: cover property (@(posedge sys_clk_i) state_reg == HBL_ACTIVE && log_full);
endmodule

// ==== sim/hbl_sensor_model.sv ====
`timescale 1ns/10ps
module hbl_sensor_model
  import hbl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Sample output
  output logic smp_valid_o,
  output hbl_sample_t smp_o
);
  logic pend;
  hbl_sample_t pend_smp;
  initial begin
    pend = 1'b0;
    pend_smp = '0;
    smp_valid_o = 1'b0;
    smp_o = '0;
  end
  // Data toggles between samples so a stale value never looks valid
  always @(posedge sys_clk_i) begin
    smp_valid_o <= pend && !rst_i;
    smp_o <= pend ? pend_smp : ~smp_o;
  end
  // One-cycle sample pulse, then time for counters and alarms to settle
  task automatic send(input logic h, input logic [15:0] v);
    pend_smp <= '{is_hum: h, value: v};
    pend <= 1'b1;
    @(posedge sys_clk_i);
    pend <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
endmodule

// ==== sim/histogram_bin_logger_tb.sv ====
`timescale 1ns/10ps
module histogram_bin_logger_tb;
  import hbl_pkg::*;
  localparam int TPS = 10;
  logic clk, rst, rd, wr, smp_valid, req, irq;
  logic [7:0] adr;
  logic [31:0] wd, rdata, d;
  logic waitreq;
  logic [1:0] bat;
  hbl_sample_t smp;
  hbl_state_t state;
  int n_errors = 0;
  int n_checks = 0;
  int t1, t2;
  logic [7:0] ra [10] = '{HBL_OFF_CTRL, HBL_OFF_STATUS, HBL_OFF_CNT_EN, HBL_OFF_VAL_KEEP,
    HBL_OFF_STAMP_KEEP, HBL_OFF_UPPER, 8'h58, HBL_OFF_PERIOD, HBL_OFF_LEVEL, 8'h3C};
  logic [31:0] rv [10] = '{32'h0, 32'hC, 32'h41, 32'h41, 32'h0, 32'h8C0, 32'hC80, 32'h1E,
    32'hFFFF, 32'h0};

  hbl_logger #(.TICKS_PER_S(TPS)) i_hbl_logger (.sys_clk_i(clk), .rst_i(rst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .smp_valid_i(smp_valid),
    .smp_i(smp), .bat_level_i(bat), .sample_req_o(req), .state_o(state), .irq_o(irq));
  hbl_sensor_model i_hbl_sensor_model (.sys_clk_i(clk), .rst_i(rst),
    .smp_valid_o(smp_valid), .smp_o(smp));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d mismatches", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_errors++;
        $display("MISMATCH waitrequest expected 0 seen 1");
        tally_and_finish;
      end
      @(posedge clk);
    end
    d = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, d);
  endtask
  task automatic wait_state(input hbl_state_t e, input string nm);
    int n;
    n = 0;
    while (state !== e && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(nm, 32'(e), 32'(state));
    if (state !== e) tally_and_finish;
  endtask
  task automatic wait_req(output int t);
    int n;
    n = 0;
    @(posedge clk);
    while (req !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    t = n;
    if (req !== 1'b1) begin
      n_errors++;
      $display("MISMATCH sample request expected 1 seen 0");
      tally_and_finish;
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("MISMATCH run length expected done seen timeout");
    tally_and_finish;
  end

  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    bat = 2'h3;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("state", 32'(HBL_IDLE), 32'(state));
    chk("irq", 32'h0, {31'h0, irq});
    for (int i = 0; i < 10; i++) begin
      rdc(ra[i], rv[i], "reset value");
    end
    rdc(HBL_OFF_LOG_PTR, 32'h0, "log ptr");
    $display("test reset done");

    bus(1'b1, HBL_OFF_CTRL, 32'h1);
    wait_state(HBL_ACTIVE, "start");
    bus(1'b1, HBL_OFF_UPPER, 32'h0100);
    bus(1'b1, HBL_OFF_UPPER + 8'h04, 32'h0200);
    bus(1'b1, HBL_OFF_UPPER + 8'h08, 32'h0300);
    bus(1'b1, HBL_OFF_CNT_EN, 32'h043);
    i_hbl_sensor_model.send(1'b0, 16'h0100);
    i_hbl_sensor_model.send(1'b0, 16'h0101);
    i_hbl_sensor_model.send(1'b0, 16'h0250);
    i_hbl_sensor_model.send(1'b0, 16'h0000);
    i_hbl_sensor_model.send(1'b1, 16'h0010);
    rdc(HBL_OFF_LEVEL, 32'h0002_FFFF, "hits t0");
    rdc(HBL_OFF_LEVEL + 8'h04, 32'h0001_FFFF, "hits t1");
    rdc(HBL_OFF_LEVEL + 8'h08, 32'h0000_FFFF, "hits t2");
    rdc(HBL_OFF_LEVEL + 8'h18, 32'h0001_FFFF, "hits h0");
    rdc(HBL_OFF_LOG_PTR, 32'h3, "log ptr");
    rdc(HBL_OFF_LOG_DATA, 32'hC000_0010, "log entry h0");
    bus(1'b1, HBL_OFF_STAMP_KEEP, 32'h002);
    i_hbl_sensor_model.send(1'b0, 16'h0180);
    rdc(HBL_OFF_LOG_PTR, 32'h4, "log ptr");
    rdc(HBL_OFF_LOG_DATA, 32'h2400_0000, "log entry t1");
    $display("test bins done");

    bus(1'b1, HBL_OFF_LEVEL + 8'h04, 32'h2);
    rdc(HBL_OFF_ALARM, 32'h2, "alarm");
    rdc(HBL_OFF_IRQ_STAT, 32'h1, "irq stat");
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, HBL_OFF_IRQ_MASK, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, HBL_OFF_LEVEL + 8'h04, 32'hFFFF);
    bus(1'b1, HBL_OFF_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc(HBL_OFF_ALARM, 32'h0, "alarm off");
    $display("test alarm done");

    i_hbl_sensor_model.send(1'b0, 16'h0000);
    bus(1'b1, HBL_OFF_PERIOD + 8'h04, 32'h2);
    i_hbl_sensor_model.send(1'b0, 16'h0150);
    wait_req(t1);
    wait_req(t1);
    wait_req(t2);
    chk("interval", 32'h1, {31'h0, t2 >= 49 && t2 <= 51});
    $display("test interval done");

    bus(1'b1, HBL_OFF_CTRL, 32'h2);
    wait_state(HBL_SLEEP, "stop");
    rdc(HBL_OFF_LOG_PTR, 32'h6, "log kept");
    rdc(HBL_OFF_IRQ_STAT, 32'h2, "sleep flag");
    rdc(HBL_OFF_LEVEL, 32'h0003_FFFF, "hits kept");
    bus(1'b1, HBL_OFF_CTRL, 32'h4);
    wait_state(HBL_IDLE, "reset cmd");
    rdc(HBL_OFF_LOG_PTR, 32'h0, "log cleared");
    rdc(HBL_OFF_LEVEL, 32'h0000_FFFF, "hits cleared");
    $display("test sleep done");

    bus(1'b1, HBL_OFF_CTRL, 32'h1);
    wait_state(HBL_ACTIVE, "restart");
    for (int i = 0; i < HBL_LOG_DEPTH - 1; i++) begin
      i_hbl_sensor_model.send(1'b0, 16'h0000);
    end
    chk("not full", 32'(HBL_ACTIVE), 32'(state));
    i_hbl_sensor_model.send(1'b0, 16'h0000);
    wait_state(HBL_SLEEP, "log full");
    bus(1'b0, HBL_OFF_IRQ_STAT, 32'h0);
    chk("full flag", 32'h1, {31'h0, d[HBL_IRQ_FULL]});
    $display("test full done");

    bus(1'b1, HBL_OFF_CTRL, 32'h4);
    wait_state(HBL_IDLE, "reset cmd");
    bus(1'b1, HBL_OFF_CTRL, 32'h1);
    wait_state(HBL_ACTIVE, "restart");
    bat <= HBL_BAT_EMPTY;
    wait_state(HBL_SLEEP, "battery empty");
    bat <= 2'h3;
    $display("test battery done");
    tally_and_finish;
  end
endmodule
